//--- core/scs_pkg.sv
/*
  constants and carrier types for the serial configuration slave.
  assumes the board controller drives the serial configuration clock and
  the serial strobes, and that a 10 MHz system clock runs all the time.

// Operation
// - write strobe captures address and data together
// - read strobe latches the shifted read address
// - selected register shifts out lsb first
// - no slave built: serial output held low
// - unused soft reset request held high
// - all shifting runs on controller's serial clock
// - 12-bit address field, 32-bit data field
// - defaults reset reloads every register's default
*/
package scs_pkg;
  localparam int ADDR_W       = 12;           // address field width
  localparam int DATA_W       = 32;           // data field width
  localparam int FRAME_W      = ADDR_W + DATA_W; // full write frame
  localparam int ADDR_LSB     = DATA_W;       // address sits above data
  localparam int CLK_FREQ_KHZ = 10000;        // system clock rate
  localparam int LINK_FREQ_KHZ = 500;         // serial clock rate
  // system cycles in one serial period, rounded down
  localparam int LINK_PERIOD_CYCLES = CLK_FREQ_KHZ / LINK_FREQ_KHZ;
  localparam logic [31:0] DEFAULT_WORD = 32'h0000_0000; // reset contents
  localparam logic [31:0] UNMAPPED_WORD = 32'h0000_0000; // read of a hole

  // one captured transfer, handed from the serial side
  typedef struct packed {
    logic [ADDR_W-1:0] addr;                  // register address
    logic [DATA_W-1:0] data;                  // write data
  } scs_req_t;
endpackage

//--- core/scs_slave.sv
/*
  serial configuration slave: shifts frames in on the controller's clock,
  hands writes and read addresses to the system clock domain through
  toggle handshakes, and shifts read data back out lsb first.
  assumes the controller leaves at least four serial clocks between a
  read strobe and the first read data bit it samples, and at least four
  serial clocks between the strobes of consecutive transfers.
*/
module scs_slave #(
  parameter int NREGS       = 8,   // configuration words built
  parameter bit IMPLEMENTED = 1'b1 // 0 = tie-off image only
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   serial_config_clock,
  input  wire logic                   defaults_reset_n,
  input  wire logic                   load_strobe,
  input  wire logic                   write_not_read_select,
  input  wire logic                   serial_data_to_slave,
  output logic                        serial_data_from_slave,
  output logic                        soft_reset_request_n,
  output logic [NREGS-1:0][31:0]      config_words
);
  localparam int AW = scs_pkg::ADDR_W;

  // address decode shared by write, read and checks; one spare bit so a
  // full-size build does not wrap the bound to zero and refuse everything
  function automatic logic in_range(input logic [AW-1:0] a);
    return {1'b0, a} < (AW+1)'(NREGS);
  endfunction

  // refuse sizes the address field cannot reach
  if (NREGS < 1 || NREGS > (1 << AW))
    $error("scs_slave: NREGS out of range");
  if (scs_pkg::LINK_PERIOD_CYCLES < 4)
    $error("scs_slave: system clock too slow for the handshake");

  // ---- link domain state ----
  logic                        lrst_m;     // reset sync, first stage
  logic                        lrst;       // reset in link domain
  logic [scs_pkg::FRAME_W-1:0] sr;         // input shift register
  scs_pkg::scs_req_t           wr_req;     // held write transfer
  logic [AW-1:0]               rd_addr;    // held read address
  logic                        wr_tgl;     // write event toggle
  logic                        rd_tgl;     // read event toggle
  logic                        ack_m;      // ack sync, first stage
  logic                        ack_s;      // ack sync, second stage
  logic                        ack_d;      // ack edge history
  logic [31:0]                 out_sr;     // read data shifter
  logic                        ack_edge;   // read word has arrived

  // ---- system domain state ----
  logic                        dr_m;       // defaults sync, first stage
  logic                        dr_s;       // defaults request, high=load
  logic [2:0]                  wr_sync;    // write toggle sync + history
  logic [2:0]                  rd_sync;    // read toggle sync + history
  logic [31:0]                 rd_word;    // word answering a read
  logic                        ack_tgl;    // read answer toggle
  logic                        wr_pulse;   // one write to apply
  logic                        rd_pulse;   // one read to answer

  // unused soft reset request stays inactive for good
  assign soft_reset_request_n = 1'b1;

  // reset brought onto the serial clock
  always_ff @(posedge serial_config_clock)
  begin
    lrst_m <= reset;
    lrst   <= lrst_m;
  end

  // frame shifter, rising edge; a strobe edge carries no data bit
  always_ff @(posedge serial_config_clock)
  begin
    if (lrst)
      sr <= '0;
    else if (!load_strobe)
      sr <= {sr[scs_pkg::FRAME_W-2:0], serial_data_to_slave};
  end

  // strobe ends a write: address and data taken in one edge
  always_ff @(posedge serial_config_clock)
  begin
    if (lrst)
    begin
      wr_req <= '0;
      wr_tgl <= 1'b0;
    end
    else if (load_strobe && write_not_read_select)
    begin
      wr_req.addr <= sr[scs_pkg::ADDR_LSB +: AW];
      wr_req.data <= sr[scs_pkg::DATA_W-1:0];
      wr_tgl      <= ~wr_tgl;
    end
  end

  // strobe starts a read: only the address was shifted in
  always_ff @(posedge serial_config_clock)
  begin
    if (lrst)
    begin
      rd_addr <= '0;
      rd_tgl  <= 1'b0;
    end
    else if (load_strobe && !write_not_read_select)
    begin
      rd_addr <= sr[AW-1:0];
      rd_tgl  <= ~rd_tgl;
    end
  end

  // read answer back onto the serial clock; word is stable by now
  always_ff @(posedge serial_config_clock)
  begin
    if (lrst)
    begin
      ack_m <= 1'b0;
      ack_s <= 1'b0;
      ack_d <= 1'b0;
    end
    else
    begin
      ack_m <= ack_tgl;
      ack_s <= ack_m;
      ack_d <= ack_s;
    end
  end
  assign ack_edge = ack_s ^ ack_d;

  // read shifter: load on answer, else move one bit toward lsb
  always_ff @(posedge serial_config_clock)
  begin
    if (lrst)
      out_sr <= '0;
    else if (ack_edge)
      out_sr <= rd_word;
    else
      out_sr <= {1'b0, out_sr[31:1]};
  end

  // output pin changes on the falling edge, half a period of margin
  always_ff @(negedge serial_config_clock)
  begin
    if (lrst || !IMPLEMENTED)
      serial_data_from_slave <= 1'b0;
    else
      serial_data_from_slave <= out_sr[0];
  end

  // defaults request from the pin, two stages before use
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      dr_m <= 1'b0;
      dr_s <= 1'b0;
    end
    else
    begin
      dr_m <= ~defaults_reset_n;
      dr_s <= dr_m;
    end
  end

  // event toggles into the system clock; stage 0 feeds stage 1 only
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_sync <= '0;
      rd_sync <= '0;
    end
    else
    begin
      wr_sync <= {wr_sync[1:0], wr_tgl};
      rd_sync <= {rd_sync[1:0], rd_tgl};
    end
  end
  assign wr_pulse = wr_sync[1] ^ wr_sync[2];
  assign rd_pulse = rd_sync[1] ^ rd_sync[2];

  // configuration words; defaults win over a write in the same cycle
  always_ff @(posedge clk)
  begin
    if (reset || dr_s)
      config_words <= {NREGS{scs_pkg::DEFAULT_WORD}};
    else if (wr_pulse && in_range(wr_req.addr))
      config_words[wr_req.addr] <= wr_req.data;
  end

  // read answer: word and toggle leave together, word held till next
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rd_word <= '0;
      ack_tgl <= 1'b0;
    end
    else if (rd_pulse)
    begin
      // holes read as a fixed word rather than aliasing
      rd_word <= in_range(rd_addr) ? config_words[rd_addr]
                                   : scs_pkg::UNMAPPED_WORD;
      ack_tgl <= ~ack_tgl;
    end
  end

  // ---- checks ----
  // link reset copy is unknown for its first two serial edges, so the
  // system reset also holds the link-side checks off until it settles
  wr_capture_a: assert property (@(posedge serial_config_clock)
    disable iff (lrst || reset)
    load_strobe && write_not_read_select |=>
      wr_tgl != $past(wr_tgl) &&
      wr_req == $past(sr) && $stable(sr))
    else $error("write strobe did not capture the frame");

  rd_latch_a: assert property (@(posedge serial_config_clock)
    disable iff (lrst || reset)
    load_strobe && !write_not_read_select |=>
      rd_addr == $past(sr[AW-1:0]) && $stable(wr_tgl))
    else $error("read strobe did not latch the address");

  // load edge, then first shift edge; compare one edge after that shift
  rd_lsb_first_a: assert property (@(posedge serial_config_clock)
    disable iff (lrst || reset)
    ack_edge ##1 !ack_edge |=> out_sr == {1'b0, $past(out_sr[31:1])})
    else $error("read data not shifted lsb first");

  tie_low_a: assert property (@(posedge clk) disable iff (reset)
    IMPLEMENTED || !serial_data_from_slave)
    else $error("serial output not low without a slave");

  soft_req_high_a: assert property (@(posedge clk)
    disable iff (reset) soft_reset_request_n)
    else $error("soft reset request left active");

  shift_in_a: assert property (@(posedge serial_config_clock)
    disable iff (lrst || reset)
    !load_strobe |=>
      sr[scs_pkg::FRAME_W-1:1] == $past(sr[scs_pkg::FRAME_W-2:0]))
    else $error("frame shifter did not advance");

  wr_apply_a: assert property (@(posedge clk) disable iff (reset)
    wr_pulse && !dr_s && in_range(wr_req.addr) |=>
      config_words[$past(wr_req.addr)] == $past(wr_req.data))
    else $error("write not applied to its register");

  defaults_a: assert property (@(posedge clk) disable iff (reset)
    !defaults_reset_n [*3] |=> config_words == {NREGS{scs_pkg::DEFAULT_WORD}})
    else $error("defaults reset did not reload registers");

  out_edge_a: assert property (@(posedge serial_config_clock)
    disable iff (lrst || reset)
    IMPLEMENTED |-> serial_data_from_slave == out_sr[0])
    else $error("output bit not driven on falling edge");
endmodule

//--- verif/scs_ctrl_model.sv
/*
  board controller model: drives frames on the serial link.
  assumes the slave samples on rising serial edges.
*/
module scs_ctrl_model (
  output logic      serial_config_clock,
  output logic      load_strobe,
  output logic      write_not_read_select,
  output logic      serial_data_to_slave,
  input  wire logic serial_data_from_slave
);
  timeunit 1ns;
  timeprecision 1ps;
  // link clock stands low between frames
  initial
  begin
    serial_config_clock = 1'b0;
    load_strobe = 1'b0;
    write_not_read_select = 1'b0;
    serial_data_to_slave = 1'b0;
  end
  // one 64 ns period; gap stretches the low phase for the slow side
  task automatic tick(input logic ld, input logic w, input logic d,
                      input int gap);
    load_strobe = ld;
    write_not_read_select = w;
    serial_data_to_slave = d;
    #32 serial_config_clock = 1'b1;
    #32 serial_config_clock = 1'b0;
    #gap;
  endtask
  // address then data msb first, strobe with a flipped bit, then an idle bit
  task automatic send_write(input scs_pkg::scs_req_t f);
    for (int i = 43; i >= 0; i--)
      tick(1'b0, 1'b1, f[i], 0);
    tick(1'b1, 1'b1, ~f[0], 0);
    tick(1'b0, 1'b1, f[0], 1000);
  endtask
  // address, strobe, idle edges, then 33 samples lsb first
  task automatic send_read(input logic [11:0] a, output logic [32:0] q);
    for (int i = 11; i >= 0; i--)
      tick(1'b0, 1'b0, a[i], 0);
    tick(1'b1, 1'b0, ~a[0], 1000);
    tick(1'b0, 1'b0, a[0], 1000);
    tick(1'b0, 1'b0, ~a[0], 1000);
    tick(1'b0, 1'b0, a[0], 1000);
    for (int i = 0; i < 33; i++)
    begin
      #32 q[i] = serial_data_from_slave;
      serial_config_clock = 1'b1;
      #32 serial_config_clock = 1'b0;
    end
  endtask
endmodule

//--- verif/testbench.sv
/*
  self-checking bench for the serial configuration slave.
  assumes the controller model owns every serial pin.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // one row: frame sent and word expected back
  typedef struct packed {
    scs_pkg::scs_req_t req;
    logic [31:0]       rd;
  } scs_row_t;
  logic             clk;
  logic             reset;
  logic             defaults_reset_n;
  logic             sclk;
  logic             load;
  logic             wnr;
  logic             sdi;
  logic             sdo;
  logic             sdo_tie;
  logic             srr_n;
  logic [7:0][31:0] words;
  logic [31:0]      exp_words [8];
  logic [32:0]      q;
  scs_row_t         rows [5];
  int               errors;
  int               cmp_count;
  scs_slave #(.NREGS(8), .IMPLEMENTED(1'b1)) u_dut (.clk(clk),
    .reset(reset), .serial_config_clock(sclk),
    .defaults_reset_n(defaults_reset_n), .load_strobe(load),
    .write_not_read_select(wnr), .serial_data_to_slave(sdi),
    .serial_data_from_slave(sdo), .soft_reset_request_n(srr_n),
    .config_words(words));
  // tie-off image shares the link to show its idle output
  scs_slave #(.NREGS(8), .IMPLEMENTED(1'b0)) u_tie (.clk(clk),
    .reset(reset), .serial_config_clock(sclk),
    .defaults_reset_n(defaults_reset_n), .load_strobe(load),
    .write_not_read_select(wnr), .serial_data_to_slave(sdi),
    .serial_data_from_slave(sdo_tie), .soft_reset_request_n(),
    .config_words());
  scs_ctrl_model u_ctrl (.serial_config_clock(sclk), .load_strobe(load),
    .write_not_read_select(wnr), .serial_data_to_slave(sdi),
    .serial_data_from_slave(sdo));
  always #50 clk = ~clk;
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task automatic check_words();
    for (int i = 0; i < 8; i++)
      check(words[i] === exp_words[i], "config word");
  endtask
  task automatic report_and_stop();
    $display("errors=%0d compares=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // hang guard
  initial
  begin
    #1000000;
    errors++;
    report_and_stop();
  end
  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    defaults_reset_n = 1'b1;
    errors = 0;
    cmp_count = 0;
    foreach (exp_words[i]) exp_words[i] = 32'h0000_0000;
    // edges of words and refused addresses
    rows[0] = '{'{12'h000, 32'h8000_0001}, 32'h8000_0001};
    rows[1] = '{'{12'h007, 32'ha5a5_5a5a}, 32'ha5a5_5a5a};
    rows[2] = '{'{12'h003, 32'hffff_fffe}, 32'hffff_fffe};
    rows[3] = '{'{12'h008, 32'h1234_5678}, 32'h0000_0000};
    rows[4] = '{'{12'hfff, 32'hdead_beef}, 32'h0000_0000};
    // link domain needs serial edges while reset is held
    fork
      repeat (4) u_ctrl.tick(1'b0, 1'b0, 1'b0, 0);
      repeat (6) @(negedge clk);
    join
    reset = 1'b0;
    repeat (3) u_ctrl.tick(1'b0, 1'b0, 1'b0, 0);
    check_words();
    check(srr_n === 1'b1, "soft reset request");
    foreach (rows[i])
    begin
      u_ctrl.send_write(rows[i].req);
      if (rows[i].req.addr < 12'h008)
        exp_words[rows[i].req.addr[2:0]] = rows[i].req.data;
      check_words();
      u_ctrl.send_read(rows[i].req.addr, q);
      check(q[31:0] === rows[i].rd, "read data");
      check(q[32] === 1'b0, "idle after word");
      check(sdo_tie === 1'b0, "tie-off output");
    end
    // defaults reset clears every word
    @(negedge clk);
    defaults_reset_n = 1'b0;
    repeat (5) @(negedge clk);
    defaults_reset_n = 1'b1;
    repeat (4) @(negedge clk);
    foreach (exp_words[i]) exp_words[i] = 32'h0000_0000;
    check_words();
    u_ctrl.send_read(12'h007, q);
    check(q[31:0] === 32'h0000_0000, "read after defaults");
    report_and_stop();
  end
endmodule
